// [panel_power_sequencer.sv]
/*
 Panel power sequencer: power management register on a plain register port,
 internal up/down sequencing of the four panel controls, external pass-through.
 Assumes ext request inputs are asynchronous pins; register port is on clk_sys.
*/
`default_nettype none
module panel_power_sequencer
    import pps_pkg::*;
#(
    parameter int TICK_CYCLES = PPS_TICK_CYCLES
) (
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    output logic [31:0] reg_rdata,
    input wire logic ext_supply_request_in,
    input wire logic ext_contrast_request_in,
    output logic panel_supply_enable,
    output logic panel_data_enable,
    output logic contrast_voltage_enable,
    output logic backlight_off_n
);
    pps_timer_if tif ();
    pps_phase_timer #(
        .TICK_CYCLES(TICK_CYCLES)
    ) u_timer (
        .clk_sys(clk_sys),
        .resetn(resetn),
        .tif(tif)
    );

    logic [31:0] ctrl_q;
    logic [1:0] ext_sup_sync_q;
    logic [1:0] ext_con_sync_q;
    pps_level_type level_q;
    logic going_up_q;
    logic busy_q;
    logic wr_hit;
    logic req_rise;
    logic req_fall;
    logic internal_mode;
    logic bl_indep;
    logic start_q;
    logic long_q;
    logic wr_seq;
    logic [3:0] seq_ctl;

    assign wr_hit = reg_write && (reg_addr == PPS_PWR_MGMT_OFFSET);
    assign internal_mode = !ctrl_q[PPS_SEQ_SEL_BIT];
    assign bl_indep = ctrl_q[PPS_BL_SRC_BIT];
    // A write that also picks external mode starts nothing
    assign wr_seq = wr_hit && !reg_wdata[PPS_SEQ_SEL_BIT];
    // Only a change of the request bit counts as a command
    assign req_rise = wr_seq && !ctrl_q[PPS_PWR_REQ_BIT] && reg_wdata[PPS_PWR_REQ_BIT];
    assign req_fall = wr_seq && ctrl_q[PPS_PWR_REQ_BIT] && !reg_wdata[PPS_PWR_REQ_BIT];

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ctrl_q <= PPS_PWR_MGMT_RESET;
        end else if (wr_hit) begin
            ctrl_q <= reg_wdata & PPS_WR_MASK;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            reg_rdata <= 32'h00000000;
        end else if (reg_read && reg_addr == PPS_PWR_MGMT_OFFSET) begin
            reg_rdata <= ctrl_q;
        end else begin
            reg_rdata <= 32'h00000000;
        end
    end

    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            ext_sup_sync_q <= 2'b00;
            ext_con_sync_q <= 2'b00;
        end else begin
            ext_sup_sync_q <= {ext_sup_sync_q[0], ext_supply_request_in};
            ext_con_sync_q <= {ext_con_sync_q[0], ext_contrast_request_in};
        end
    end

    // Delay of the phase that follows reaching a level in the given direction
    function automatic logic phase_long(input pps_level_type lvl, input logic up, input logic [31:0] c);
        logic r;
        r = 1'b0;
        if (up) begin
            case (lvl)
                PPS_SUPPLY: r = c[PPS_UP_SD_BIT];
                PPS_DATA: r = c[PPS_UP_DC_BIT];
                // Independent backlight makes its phases the short fixed delay
                PPS_CONTRAST: r = c[PPS_UP_CB_BIT] && !c[PPS_BL_SRC_BIT];
                default: r = 1'b0;
            endcase
        end else begin
            case (lvl)
                PPS_CONTRAST: r = c[PPS_DN_BC_BIT] && !c[PPS_BL_SRC_BIT];
                PPS_DATA: r = c[PPS_DN_CD_BIT];
                PPS_SUPPLY: r = c[PPS_DN_DS_BIT];
                default: r = 1'b0;
            endcase
        end
        return r;
    endfunction : phase_long

    // Sequencer: first step of a fresh sequence is immediate, later ones wait a phase
    always_ff @(posedge clk_sys) begin
        start_q <= 1'b0;
        if (!resetn) begin
            level_q <= PPS_OFF;
            going_up_q <= 1'b0;
            busy_q <= 1'b0;
            long_q <= 1'b0;
        end else if (!internal_mode) begin
            busy_q <= 1'b0;
            going_up_q <= ctrl_q[PPS_PWR_REQ_BIT];
        end else if (req_rise) begin
            going_up_q <= 1'b1;
            if (level_q == PPS_OFF) begin
                level_q <= PPS_SUPPLY;
                start_q <= 1'b1;
                long_q <= phase_long(PPS_SUPPLY, 1'b1, reg_wdata);
                busy_q <= 1'b1;
            end else if (level_q != PPS_ON) begin
                start_q <= 1'b1;
                long_q <= phase_long(level_q, 1'b1, reg_wdata);
                busy_q <= 1'b1;
            end
        end else if (req_fall) begin
            going_up_q <= 1'b0;
            if (level_q == PPS_ON) begin
                // Backlight goes dark at once, contrast then waits its phase
                level_q <= PPS_CONTRAST;
                start_q <= 1'b1;
                long_q <= phase_long(PPS_CONTRAST, 1'b0, reg_wdata);
                busy_q <= 1'b1;
            end else if (level_q != PPS_OFF) begin
                start_q <= 1'b1;
                long_q <= phase_long(level_q, 1'b0, reg_wdata);
                busy_q <= 1'b1;
            end
        end else if (busy_q && tif.done && !start_q) begin
            // A done beside a fresh start belongs to the abandoned phase
            if (going_up_q) begin
                level_q <= pps_level_type'(level_q + 3'b001);
                if (level_q != PPS_CONTRAST) begin
                    start_q <= 1'b1;
                    long_q <= phase_long(pps_level_type'(level_q + 3'b001), 1'b1, ctrl_q);
                end else begin
                    busy_q <= 1'b0;
                end
            end else begin
                level_q <= pps_level_type'(level_q - 3'b001);
                if (level_q != PPS_SUPPLY) begin
                    start_q <= 1'b1;
                    long_q <= phase_long(pps_level_type'(level_q - 3'b001), 1'b0, ctrl_q);
                end else begin
                    busy_q <= 1'b0;
                end
            end
        end
    end

    // Panel controls implied by each level: supply, data, contrast, backlight
    always_comb begin
        seq_ctl = 4'h0;
        case (level_q)
            PPS_OFF: seq_ctl = 4'h0;
            PPS_SUPPLY: seq_ctl = 4'h8;
            PPS_DATA: seq_ctl = 4'hC;
            PPS_CONTRAST: seq_ctl = 4'hE;
            PPS_ON: seq_ctl = 4'hF;
            default: seq_ctl = 4'h0;
        endcase
    end

    assign tif.start = start_q;
    assign tif.long_sel = long_q;

    // Output drive: internal sequence or external pass-through
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            panel_supply_enable <= 1'b0;
            panel_data_enable <= 1'b0;
            contrast_voltage_enable <= 1'b0;
            backlight_off_n <= 1'b0;
        end else if (internal_mode) begin
            panel_supply_enable <= seq_ctl[3];
            panel_data_enable <= seq_ctl[2];
            contrast_voltage_enable <= seq_ctl[1];
            backlight_off_n <= !bl_indep && seq_ctl[0];
        end else begin
            // Data activity rides on the supply request in external mode
            panel_supply_enable <= ext_sup_sync_q[1];
            panel_data_enable <= ext_sup_sync_q[1];
            contrast_voltage_enable <= ext_con_sync_q[1];
            backlight_off_n <= !bl_indep && ext_con_sync_q[1];
        end
    end
endmodule : panel_power_sequencer
`default_nettype wire

// [pps_pkg.sv]
/*
 Package for the panel power sequencer: register offset, field positions,
 reset value and phase timing constants.
 Assumes a 40 MHz system clock.
*/
`default_nettype none
package pps_pkg;
    localparam logic [11:0] PPS_PWR_MGMT_OFFSET = 12'h408;
    localparam logic [31:0] PPS_PWR_MGMT_RESET = 32'h00000000;
    localparam int PPS_SEQ_SEL_BIT = 27;
    localparam int PPS_BL_SRC_BIT = 25;
    localparam int PPS_PWR_REQ_BIT = 24;
    localparam int PPS_UP_SD_BIT = 23;
    localparam int PPS_UP_DC_BIT = 22;
    localparam int PPS_UP_CB_BIT = 21;
    localparam int PPS_DN_BC_BIT = 20;
    localparam int PPS_DN_CD_BIT = 19;
    localparam int PPS_DN_DS_BIT = 18;
    // Writable bits of the power management register
    localparam logic [31:0] PPS_WR_MASK = 32'h0BFC0000;
    localparam int PPS_CLK_HZ = 40000000;
    localparam int PPS_TICK_US = 1000;
    localparam int PPS_TICK_CYCLES = PPS_CLK_HZ / 1000000 * PPS_TICK_US;
    localparam int PPS_SHORT_MS = 32;
    localparam int PPS_LONG_MS = 128;
    localparam int PPS_SHORT_TICKS = PPS_SHORT_MS * 1000 / PPS_TICK_US;
    localparam int PPS_LONG_TICKS = PPS_LONG_MS * 1000 / PPS_TICK_US;
    typedef enum logic [2:0] {
        PPS_OFF = 3'b000,
        PPS_SUPPLY = 3'b001,
        PPS_DATA = 3'b010,
        PPS_CONTRAST = 3'b011,
        PPS_ON = 3'b100
    } pps_level_type;
endpackage : pps_pkg
`default_nettype wire

// [pps_timer_if.sv]
/*
 Interface between the sequencer and its phase timer.
 Assumes a single system clock.
*/
`default_nettype none
interface pps_timer_if;
    logic start;
    logic long_sel;
    logic done;
    modport seq (output start, output long_sel, input done);
    modport tmr (input start, input long_sel, output done);
endinterface : pps_timer_if
`default_nettype wire

// [pps_phase_timer.sv]
/*
 Phase delay timer: a prescaler makes a tick each millisecond step and a
 counter measures a 32 ms or 128 ms interval after each start pulse.
 Assumes start is a one-cycle pulse on clk_sys; a new start restarts it.
*/
`default_nettype none
module pps_phase_timer
    import pps_pkg::*;
#(
    parameter int TICK_CYCLES = PPS_TICK_CYCLES,
    parameter int SHORT_TICKS = PPS_SHORT_TICKS,
    parameter int LONG_TICKS = PPS_LONG_TICKS
) (
    input wire logic clk_sys,
    input wire logic resetn,
    pps_timer_if.tmr tif
);
    logic [15:0] pre_q;
    logic [7:0] cnt_q;
    logic run_q;
    logic tick;
    logic done_q;

    assign tick = (pre_q == 16'(TICK_CYCLES - 1));
    assign tif.done = done_q;

    // Prescaler restarts with each phase so every interval is whole ticks
    always_ff @(posedge clk_sys) begin
        if (!resetn || tif.start || tick) begin
            pre_q <= 16'h0000;
        end else if (run_q) begin
            pre_q <= pre_q + 16'h0001;
        end
    end

    always_ff @(posedge clk_sys) begin
        done_q <= 1'b0;
        if (!resetn) begin
            run_q <= 1'b0;
            cnt_q <= 8'h00;
        end else if (tif.start) begin
            run_q <= 1'b1;
            cnt_q <= tif.long_sel ? 8'(LONG_TICKS - 1) : 8'(SHORT_TICKS - 1);
        end else if (run_q && tick) begin
            if (cnt_q == 8'h00) begin
                run_q <= 1'b0;
                done_q <= 1'b1;
            end else begin
                cnt_q <= cnt_q - 8'h01;
            end
        end
    end
endmodule : pps_phase_timer
`default_nettype wire

// [pps_monitor.sv]
/*
 Port checker for the panel power sequencer.
 Assumes one clock, clk_sys, and a synchronous active-low resetn.
*/
`default_nettype none
module pps_monitor
    import pps_pkg::*;
(
    input wire logic clk_sys,
    input wire logic resetn,
    input wire logic [11:0] reg_addr,
    input wire logic [31:0] reg_wdata,
    input wire logic reg_write,
    input wire logic reg_read,
    input wire logic [31:0] reg_rdata,
    input wire logic ext_supply_request_in,
    input wire logic ext_contrast_request_in,
    input wire logic panel_supply_enable,
    input wire logic panel_data_enable,
    input wire logic contrast_voltage_enable,
    input wire logic backlight_off_n
);
    timeunit 1ns;
    timeprecision 1ps;
    // Shadow of select, backlight source and power request
    logic [2:0] cfg_q;
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            cfg_q <= 3'h0;
        end else if (reg_write && reg_addr == PPS_PWR_MGMT_OFFSET) begin
            cfg_q <= {reg_wdata[PPS_SEQ_SEL_BIT], reg_wdata[PPS_BL_SRC_BIT], reg_wdata[PPS_PWR_REQ_BIT]};
        end
    end
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!resetn);
    property p_rd;
        reg_read && reg_addr == PPS_PWR_MGMT_OFFSET |=> reg_rdata[PPS_PWR_REQ_BIT] == cfg_q[0];
    endproperty
    a_rd: assert property (p_rd) else $error("request readback wrong");
    property p_ext_sup;
        cfg_q[2] && $past(cfg_q[2], 4) |-> panel_supply_enable == $past(ext_supply_request_in, 3);
    endproperty
    a_ext_sup: assert property (p_ext_sup) else $error("supply not following pin");
    property p_ext_con;
        cfg_q[2] && $past(cfg_q[2], 4) |-> contrast_voltage_enable == $past(ext_contrast_request_in, 3);
    endproperty
    a_ext_con: assert property (p_ext_con) else $error("contrast not following pin");
    property p_ext_dat;
        cfg_q[2] && $past(cfg_q[2], 5) |-> panel_data_enable == panel_supply_enable;
    endproperty
    a_ext_dat: assert property (p_ext_dat) else $error("sequence running in external mode");
    property p_bl;
        cfg_q[1] && $past(cfg_q[1], 2) |-> !backlight_off_n;
    endproperty
    a_bl: assert property (p_bl) else $error("backlight on under independent control");
    property p_up_dat;
        $rose(panel_data_enable) && !cfg_q[2] |-> $past(panel_supply_enable, 120);
    endproperty
    a_up_dat: assert property (p_up_dat) else $error("data enabled too early");
    property p_up_bl;
        $rose(backlight_off_n) && !cfg_q[2] |-> contrast_voltage_enable && panel_data_enable;
    endproperty
    a_up_bl: assert property (p_up_bl) else $error("backlight on before contrast");
    property p_dn_sup;
        $fell(panel_supply_enable) && !cfg_q[2] |-> !panel_data_enable && !contrast_voltage_enable;
    endproperty
    a_dn_sup: assert property (p_dn_sup) else $error("supply dropped before data");
    c_up: cover property ($rose(backlight_off_n));
    c_dn: cover property ($fell(panel_supply_enable));
    c_ext: cover property (cfg_q[2] && panel_supply_enable);
endmodule : pps_monitor
bind panel_power_sequencer pps_monitor u_mon (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .ext_supply_request_in(ext_supply_request_in), .ext_contrast_request_in(ext_contrast_request_in),
    .panel_supply_enable(panel_supply_enable), .panel_data_enable(panel_data_enable),
    .contrast_voltage_enable(contrast_voltage_enable), .backlight_off_n(backlight_off_n));
`default_nettype wire

// [pps_panel_model.sv]
/*
 Model of the panel power switches and backlight inverter.
 Assumes it is fed by the sequencer's four panel outputs.
*/
`default_nettype none
module pps_panel_model (
    input wire logic supply,
    input wire logic data,
    input wire logic contrast,
    input wire logic bl_n,
    output logic lit
);
    timeunit 1ns;
    timeprecision 1ps;
    // Picture shows only with every rail and the inverter on
    assign lit = supply & data & contrast & bl_n;
endmodule : pps_panel_model
`default_nettype wire

// [panel_power_sequencer_test.sv]
/*
 Self-checking bench for the panel power sequencer.
 Assumes the design, its package, the checker and the panel model are compiled first.
*/
`default_nettype none
module panel_power_sequencer_test
    import pps_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int TK = 4;
    localparam int S = PPS_SHORT_TICKS * TK;
    localparam int L = PPS_LONG_TICKS * TK;
    localparam logic [11:0] OFF = PPS_PWR_MGMT_OFFSET;
    logic clk_sys = 1'b0;
    logic resetn = 1'b0;
    logic [11:0] reg_addr = 12'h000;
    logic [31:0] reg_wdata = 32'h00000000;
    logic reg_write = 1'b0;
    logic reg_read = 1'b0;
    logic ext_sup = 1'b0;
    logic ext_con = 1'b0;
    logic [31:0] reg_rdata;
    logic sup, dat, con, bl_n, lit;
    logic [3:0] lvl;
    int n_fail = 0;
    int checks = 0;
    assign lvl = {sup, dat, con, bl_n};
    always #12.5 clk_sys = ~clk_sys;
    panel_power_sequencer #(.TICK_CYCLES(TK)) dut (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_write(reg_write), .reg_read(reg_read), .reg_rdata(reg_rdata),
        .ext_supply_request_in(ext_sup), .ext_contrast_request_in(ext_con), .panel_supply_enable(sup),
        .panel_data_enable(dat), .contrast_voltage_enable(con), .backlight_off_n(bl_n));
    pps_panel_model panel (.supply(sup), .data(dat), .contrast(con), .bl_n(bl_n), .lit(lit));
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error at %0t: saw %h, expected %h", $time, seen, exp);
        end
    endtask : chk
    task wr(input logic [11:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_wdata <= d;
        reg_write <= 1'b1;
        @(posedge clk_sys);
        reg_write <= 1'b0;
    endtask : wr
    task rd(input logic [11:0] a, input logic [31:0] e);
        @(posedge clk_sys);
        reg_addr <= a;
        reg_read <= 1'b1;
        @(posedge clk_sys);
        reg_read <= 1'b0;
        @(negedge clk_sys);
        chk(reg_rdata, e);
    endtask : rd
    // Waits for an output level and checks how many cycles it took
    task step(input logic [3:0] e, input int lo, input int hi);
        int n;
        n = 0;
        while (lvl !== e && n < 3000) begin
            @(negedge clk_sys);
            n++;
        end
        chk(32'(n >= lo && n <= hi), 32'h1);
    endtask : step
    task close_out;
        $display("checks %0d n_fail %0d", checks, n_fail);
        if (n_fail == 0 && checks > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask : close_out
    initial begin
        repeat (30000) @(posedge clk_sys);
        n_fail++;
        close_out();
    end
    initial begin
        repeat (12) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(OFF, PPS_PWR_MGMT_RESET);
        rd(12'h40C, 32'h00000000);
        wr(OFF, 32'h01A00000);
        rd(OFF, 32'h01A00000);
        step(4'b1000, 0, 6);
        step(4'b1100, L - 6, L + 10);
        step(4'b1110, S - 6, S + 10);
        step(4'b1111, L - 6, L + 10);
        chk(32'(lit), 32'h1);
        wr(OFF, 32'h01000000);
        repeat (200) @(negedge clk_sys);
        chk(32'(lvl), 32'hF);
        wr(OFF, 32'h00080000);
        step(4'b1110, 0, 6);
        step(4'b1100, S - 6, S + 10);
        step(4'b1000, L - 6, L + 10);
        step(4'b0000, S - 6, S + 10);
        rd(OFF, 32'h00080000);
        wr(OFF, 32'h01000000);
        step(4'b1000, 0, 6);
        wr(OFF, 32'h00000000);
        step(4'b0000, S - 8, S + 10);
        wr(OFF, 32'h03E00000);
        step(4'b1000, 0, 6);
        step(4'b1100, L - 6, L + 10);
        step(4'b1110, L - 6, L + 10);
        repeat (S + 10) @(negedge clk_sys);
        wr(OFF, 32'h01E00000);
        step(4'b1111, 0, 6);
        wr(OFF, 32'h08000000);
        @(posedge clk_sys);
        ext_sup <= 1'b1;
        ext_con <= 1'b1;
        step(4'b1111, 0, 6);
        @(posedge clk_sys);
        ext_con <= 1'b0;
        step(4'b1100, 0, 6);
        @(posedge clk_sys);
        ext_con <= 1'b1;
        step(4'b1111, 0, 6);
        wr(OFF, 32'h0A000000);
        step(4'b1110, 0, 4);
        @(posedge clk_sys);
        ext_sup <= 1'b0;
        ext_con <= 1'b0;
        step(4'b0000, 0, 6);
        wr(OFF, 32'h09000000);
        repeat (300) @(negedge clk_sys);
        chk(32'(lvl), 32'h0);
        rd(OFF, 32'h09000000);
        close_out();
    end
endmodule : panel_power_sequencer_test
`default_nettype wire
